// ### rtl/sso_pkg.sv
// Constants shared by the sound stereo serial output block.
package sso_pkg;
  // Register map and control register layout.
  localparam logic [8:0] CTRL_OFF   = 9'h06c;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  localparam int         FMT_BIT    = 0;
  // Sound control field bits (serial enable, analog enable).
  localparam int         SCTL_SER   = 2;
  localparam int         SCTL_ANA   = 1;
  // Timing: the sample period register counts in microseconds.
  localparam int         US_NS      = 1000;
  localparam int         LINK_NS    = 160;
  localparam int         CYC_PER_US = US_NS / LINK_NS;
  localparam int         MIN_PER_US = 3;
  // FIFO and serial frame shape.
  localparam int         FIFO_WORDS = 4;
  localparam int         FIFO_BYTES = FIFO_WORDS * 4;
  localparam int         FRAME_BITS = 32;
  localparam int         WORD_BITS  = 16;
  localparam int         SLOTS      = 8;
  localparam int         CFG_W      = 37;
  // Stereo shares of the left pin, in sub-slots out of CYC_PER_US.
  localparam logic [2:0] SHARE_L100 = 3'd6;
  localparam logic [2:0] SHARE_L83  = 3'd5;
  localparam logic [2:0] SHARE_L67  = 3'd4;
  localparam logic [2:0] SHARE_MID  = 3'd3;
  localparam logic [2:0] SHARE_R67  = 3'd2;
  localparam logic [2:0] SHARE_R83  = 3'd1;
  localparam logic [2:0] SHARE_R100 = 3'd0;
  typedef enum logic {SSO_FILL, SSO_DRAIN} sso_fifo_e;
endpackage

// ### rtl/sso_sound_out.sv
// Sound FIFO with analog stereo slot timing and three-wire serial output.
//
// How it works
// - Codes 4..7 centre to fully right.
// - Codes 1..3 left; code 0 centre.
// - Eight channels: bytes rotate from channel 0.
// - Two channels: even slots ch0, odd ch1.
// - Slot period in microseconds, minimum three.
// - Each of eight channels refreshes at one eighth.
// - Byte bit 0 is the sign bit.
// - Sign one drives plus, zero drives minus.
// - Idle: bit clock low, data low, select high.
// - Serial bytes shift out msb first.
// - Control bit 0 selects normal or Japanese.
// - Frame is 16 left then 16 right bits.
// - Normal select moves at previous lsb, high right.
// - Japanese select moves at new msb, inverted.
// - Mute goes high between analog samples.
// - Mute covers first quarter of each slot.
// - Left-not-right high for left, low right.
// - Four-word FIFO drained byte by byte.
`timescale 1ns/100ps
module sso_sound_out
  import sso_pkg::*;
(
  input  logic        clk,                      // System clock, 10 MHz.
  input  logic        rst,                      // Synchronous reset, active high.
  input  logic        sclk,                     // Sound clock, drives the link logic.
  input  logic [8:0]  reg_addr,                 // Register byte address.
  input  logic        reg_wr,                   // Register write strobe.
  input  logic        reg_rd,                   // Register read strobe.
  input  logic [7:0]  reg_wdata,                // Register write data.
  output logic [7:0]  reg_rdata,                // Register read data.
  input  logic [2:0]  sound_ctrl,               // Sound control field.
  input  logic [1:0]  channel_mode,             // 0:1, 1:2, 2:4, 3:8 channels.
  input  logic [7:0]  sample_period_reg,        // Slot period in microseconds.
  input  logic [23:0] stereo_image_value,       // Eight 3-bit position codes.
  output logic        dma_req,                  // DMA request for four words.
  input  logic        dma_wr,                   // DMA word write strobe.
  input  logic [31:0] dma_wdata,                // DMA word.
  output logic        serial_bit_clock_out,     // Serial bit clock.
  output logic        serial_data_or_mute_out,  // Serial data or analog mute.
  output logic        word_select_left_out,     // Word select or left-not-right.
  output logic        left_plus_out,            // Left plus pin selected.
  output logic        left_minus_out,           // Left minus pin selected.
  output logic        right_plus_out,           // Right plus pin selected.
  output logic        right_minus_out,          // Right minus pin selected.
  output logic [6:0]  dac_magnitude_out,        // Sound DAC magnitude code.
  output logic [2:0]  sound_channel_out         // Channel of the current slot.
);

  // Take a bit from the third stage only once stages two and three agree.
  function automatic logic [CFG_W-1:0] agree(input logic [CFG_W-1:0] s2, input logic [CFG_W-1:0] s3,
                                             input logic [CFG_W-1:0] cur);
    agree = (s3 & ~(s2 ^ s3)) | (cur & (s2 ^ s3));
  endfunction

  // One-bit form of the same rule, for the reset and handshake synchronisers.
  function automatic logic agree_bit(input logic s2, input logic s3, input logic cur);
    agree_bit = (s2 == s3) ? s3 : cur;
  endfunction

  // Left-pin share of a slot for a position code.
  function automatic logic [2:0] left_share(input logic [2:0] code);
    case (code)
      3'd1:    left_share = SHARE_L100;
      3'd2:    left_share = SHARE_L83;
      3'd3:    left_share = SHARE_L67;
      3'd5:    left_share = SHARE_R67;
      3'd6:    left_share = SHARE_R83;
      3'd7:    left_share = SHARE_R100;
      default: left_share = SHARE_MID;
    endcase
  endfunction

  // System clock domain: FIFO, byte handover and the control register.
  sso_fifo_e   st_q, st_d;
  logic        dma_req_q, dma_req_d;
  logic [31:0] mem_q [FIFO_WORDS];
  logic [31:0] mem_d [FIFO_WORDS];
  logic [1:0]  wcnt_q, wcnt_d;
  logic [3:0]  rcnt_q, rcnt_d;
  logic [7:0]  hold_q, hold_d;
  logic        ack_q, ack_d;
  logic [2:0]  req_s_q;
  logic        req_seen_q, req_seen_d;
  logic [7:0]  ctrl_q, ctrl_d;
  logic [7:0]  rdata_q, rdata_d;
  logic        req_link_q;

  // FIFO fill and drain, byte handover and the control register.
  always_comb begin
    st_d       = st_q;
    mem_d      = mem_q;
    wcnt_d     = wcnt_q;
    rcnt_d     = rcnt_q;
    hold_d     = hold_q;
    ack_d      = ack_q;
    req_seen_d = agree_bit(req_s_q[1], req_s_q[2], req_seen_q);
    ctrl_d     = ctrl_q;
    rdata_d    = 8'h00;
    case (st_q)
      SSO_FILL: begin
        if (dma_wr) begin
          mem_d[wcnt_q] = dma_wdata;
          wcnt_d        = wcnt_q + 2'd1;
          if (wcnt_q == 2'(FIFO_WORDS - 1)) begin
            st_d   = SSO_DRAIN;
            rcnt_d = 4'h0;
          end
        end
      end
      default: begin
        if (req_seen_q != ack_q) begin
          hold_d = mem_q[rcnt_q[3:2]][8*rcnt_q[1:0] +: 8];
          ack_d  = ~ack_q;
          rcnt_d = rcnt_q + 4'h1;
          if (rcnt_q == 4'(FIFO_BYTES - 1)) begin
            st_d   = SSO_FILL;
            wcnt_d = 2'd0;
          end
        end
      end
    endcase
    if (reg_wr && reg_addr == CTRL_OFF) begin
      ctrl_d = reg_wdata;
    end
    if (reg_rd && reg_addr == CTRL_OFF) begin
      rdata_d = ctrl_q;
    end
    // Request pin registered from the next fill state.
    dma_req_d = (st_d == SSO_FILL);
  end

  // System domain registers.
  always_ff @(posedge clk) begin
    req_s_q <= {req_s_q[1:0], req_link_q};
    mem_q   <= mem_d;
    hold_q  <= hold_d;
    if (rst) begin
      st_q       <= SSO_FILL;
      wcnt_q     <= 2'd0;
      rcnt_q     <= 4'h0;
      ack_q      <= 1'b0;
      req_seen_q <= 1'b0;
      ctrl_q     <= CTRL_RST;
      rdata_q    <= 8'h00;
      dma_req_q  <= 1'b1;
    end else begin
      st_q       <= st_d;
      wcnt_q     <= wcnt_d;
      rcnt_q     <= rcnt_d;
      ack_q      <= ack_d;
      req_seen_q <= req_seen_d;
      ctrl_q     <= ctrl_d;
      rdata_q    <= rdata_d;
      dma_req_q  <= dma_req_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign dma_req   = dma_req_q;

  // Sound clock domain: synchronisers, slot timing and the pins.
  // Configuration is quasi-static; software changes it only while idle.
  logic [CFG_W-1:0] cfg_s1_q, cfg_s2_q, cfg_s3_q, cfg_q;
  logic [2:0]       rst_s_q, ack_s_q;
  logic             lrst_q, ack_seen_q;
  logic             fmt_j;
  logic [1:0]       sctl;
  logic [1:0]       chm;
  logic [7:0]       per;
  logic [23:0]      img;

  assign fmt_j = cfg_q[36];
  assign sctl  = cfg_q[35:34];
  assign chm   = cfg_q[33:32];
  assign per   = cfg_q[31:24];
  assign img   = cfg_q[23:0];

  // Three-stage synchronisers for configuration, reset and the answer toggle.
  always_ff @(posedge sclk) begin
    cfg_s1_q   <= {ctrl_q[FMT_BIT], sound_ctrl[SCTL_SER:SCTL_ANA], channel_mode, sample_period_reg,
                   stereo_image_value};
    cfg_s2_q   <= cfg_s1_q;
    cfg_s3_q   <= cfg_s2_q;
    cfg_q      <= agree(cfg_s2_q, cfg_s3_q, cfg_q);
    rst_s_q    <= {rst_s_q[1:0], rst};
    lrst_q     <= agree_bit(rst_s_q[1], rst_s_q[2], lrst_q);
    ack_s_q    <= {ack_s_q[1:0], ack_q};
    ack_seen_q <= agree_bit(ack_s_q[1], ack_s_q[2], ack_seen_q);
  end

  logic [10:0] slot_cyc_q, slot_cyc_d;
  logic [2:0]  sub_q, sub_d;
  logic [2:0]  slot_q, slot_d;
  logic [7:0]  latch_q, latch_d;
  logic [7:0]  half_q, half_d;
  logic [4:0]  bit_q, bit_d;
  logic [7:0]  shreg_q, shreg_d;
  logic        bclk_q, bclk_d;
  logic        req_d;
  logic        sdo_d, ws_d, lp_d, lm_d, rp_d, rm_d;
  logic        sdo_q, ws_q, lp_q, lm_q, rp_q, rm_q;
  logic [6:0]  mag_q, mag_d;
  logic [2:0]  chan_q, chan_d;

  // Slot timing, stereo placement, serial shifting and byte requests.
  always_comb begin
    logic [10:0] slot_len;
    logic [7:0]  fresh;
    logic        consume;
    logic        left;
    logic [2:0]  code;
    logic [4:0]  nb;
    slot_len   = 11'({3'b0, per} * 11'(CYC_PER_US));
    fresh      = (ack_seen_q == req_link_q) ? hold_q : latch_q;
    consume    = 1'b0;
    nb         = bit_q + 5'd1;
    slot_cyc_d = slot_cyc_q;
    sub_d      = sub_q;
    slot_d     = slot_q;
    latch_d    = latch_q;
    half_d     = half_q;
    bit_d      = bit_q;
    shreg_d    = shreg_q;
    bclk_d     = 1'b0;
    req_d      = req_link_q;
    mag_d      = latch_q[7:1];
    chan_d     = chan_q;
    sdo_d      = 1'b0;
    ws_d       = 1'b1;
    lp_d       = 1'b0;
    lm_d       = 1'b0;
    rp_d       = 1'b0;
    rm_d       = 1'b0;
    code       = img[3*slot_q +: 3];
    left       = (sub_q < left_share(code));
    if (sctl[1]) begin
      // Bit half-period counted from the period register.
      half_d = half_q + 8'd1;
      bclk_d = bclk_q;
      sdo_d  = shreg_q[7];
      if (half_q + 8'd1 >= per) begin
        half_d = 8'd0;
        bclk_d = ~bclk_q;
        if (bclk_q) begin
          bit_d = nb;
          // Msb first, reload every eighth bit.
          if (nb[2:0] == 3'd0) begin
            consume = 1'b1;
            shreg_d = fresh;
          end else begin
            shreg_d = {shreg_q[6:0], 1'b0};
          end
          sdo_d = shreg_d[7];
        end
      end
      // Select follows format and the bit about to go out, so a
      // frame that starts from idle already shows the right level on its first bit.
      if (fmt_j) begin
        ws_d = ~(bit_d >= 5'(WORD_BITS));
      end else begin
        // Moves with previous lsb, high on right.
        ws_d = (bit_d >= 5'(WORD_BITS - 1)) && (bit_d != 5'(FRAME_BITS - 1));
      end
    end else if (sctl[0]) begin
      // Slots rotate through all image slots.
      slot_cyc_d = slot_cyc_q + 11'd1;
      sub_d      = (sub_q == 3'(CYC_PER_US - 1)) ? 3'd0 : sub_q + 3'd1;
      if (slot_cyc_q + 11'd1 >= slot_len) begin
        slot_cyc_d = 11'd0;
        sub_d      = 3'd0;
        consume    = 1'b1;
        // Slot index selects the image for each byte.
        slot_d     = slot_q + 3'd1;
        chan_d     = slot_d & ((3'd1 << chm) - 3'd1);
      end
      // Mute the first quarter of the slot.
      if (slot_cyc_q < (slot_len >> 2)) begin
        sdo_d = 1'b1;
        ws_d  = word_select_left_out;
      end else begin
        ws_d = left;
        // Sign bit picks plus or minus pin.
        lp_d = left & latch_q[0];
        lm_d = left & ~latch_q[0];
        rp_d = ~left & latch_q[0];
        rm_d = ~left & ~latch_q[0];
      end
    end else begin
      slot_cyc_d = 11'd0;
      sub_d      = 3'd0;
      slot_d     = 3'd0;
      chan_d     = 3'd0;
      half_d     = 8'd0;
      bit_d      = 5'd0;
    end
    // A used byte asks the FIFO for the next; an unanswered ask repeats the old byte.
    if (consume && ack_seen_q == req_link_q) begin
      latch_d = hold_q;
      req_d   = ~req_link_q;
    end
  end

  // Link domain registers; every pin except the DMA request and read data comes straight from here.
  always_ff @(posedge sclk) begin
    if (lrst_q) begin
      slot_cyc_q              <= 11'd0;
      sub_q                   <= 3'd0;
      slot_q                  <= 3'd0;
      latch_q                 <= 8'h00;
      half_q                  <= 8'd0;
      bit_q                   <= 5'd0;
      shreg_q                 <= 8'h00;
      bclk_q                  <= 1'b0;
      // Leave reset with a request outstanding, so the hold register is filled before its first use.
      req_link_q              <= 1'b1;
      sdo_q                   <= 1'b0;
      ws_q                    <= 1'b1;
      lp_q                    <= 1'b0;
      lm_q                    <= 1'b0;
      rp_q                    <= 1'b0;
      rm_q                    <= 1'b0;
      mag_q                   <= 7'h00;
      chan_q                  <= 3'd0;
    end else begin
      slot_cyc_q              <= slot_cyc_d;
      sub_q                   <= sub_d;
      slot_q                  <= slot_d;
      latch_q                 <= latch_d;
      half_q                  <= half_d;
      bit_q                   <= bit_d;
      shreg_q                 <= shreg_d;
      bclk_q                  <= bclk_d;
      req_link_q              <= req_d;
      sdo_q                   <= sdo_d;
      ws_q                    <= ws_d;
      lp_q                    <= lp_d;
      lm_q                    <= lm_d;
      rp_q                    <= rp_d;
      rm_q                    <= rm_d;
      mag_q                   <= mag_d;
      chan_q                  <= chan_d;
    end
  end

  assign serial_bit_clock_out    = bclk_q;
  assign serial_data_or_mute_out = sdo_q;
  assign word_select_left_out    = ws_q;
  assign left_plus_out           = lp_q;
  assign left_minus_out          = lm_q;
  assign right_plus_out          = rp_q;
  assign right_minus_out         = rm_q;
  assign dac_magnitude_out       = mag_q;
  assign sound_channel_out       = chan_q;

endmodule

// ### sim/sso_checker.sv
// Port checker for the sound output block, bound to its top module.
`timescale 1ns/100ps
module sso_checker
  import sso_pkg::*;
(
  input logic       clk,                      // System clock.
  input logic       rst,                      // Reset, active high.
  input logic       sclk,                     // Link clock.
  input logic [8:0] reg_addr,                 // Register address.
  input logic       reg_rd,                   // Read strobe.
  input logic [7:0] reg_rdata,                // Read data.
  input logic [2:0] sound_ctrl,               // Sound control field.
  input logic [7:0] sample_period_reg,        // Period setting.
  input logic       dma_req,                  // Fill request.
  input logic       dma_wr,                   // Word strobe.
  input logic       serial_bit_clock_out,     // Bit clock.
  input logic       serial_data_or_mute_out,  // Data or mute.
  input logic       word_select_left_out,     // Word select or left.
  input logic       left_plus_out,            // Left plus.
  input logic       left_minus_out,           // Left minus.
  input logic       right_plus_out,           // Right plus.
  input logic       right_minus_out           // Right minus.
);
  logic [7:0] hi_q;
  logic [7:0] hi_d;
  logic       lpin;
  logic       anyp;
  // Length of the current bit clock high phase; settings cross in a few link cycles, hence the long windows.
  always_comb begin
    hi_d = (rst || !serial_bit_clock_out) ? 8'h00 : hi_q + 8'h01;
    lpin = left_plus_out | left_minus_out;
    anyp = lpin | right_plus_out | right_minus_out;
  end
  always_ff @(posedge sclk) begin
    hi_q <= hi_d;
  end
  sequence s_idle; (sound_ctrl[2:1] == 2'b00) [*8]; endsequence
  sequence s_ser; sound_ctrl[2] [*8]; endsequence
  sequence s_ana; (sound_ctrl[2:1] == 2'b01) [*8]; endsequence
  sequence s_fill; !dma_req ##1 (dma_req && dma_wr) [*4]; endsequence
  a_idle_pins: assert property (@(posedge sclk) disable iff (rst) s_idle |->
    !serial_bit_clock_out && !serial_data_or_mute_out && word_select_left_out) else $error("idle pins wrong");
  a_bclk_high: assert property (@(posedge sclk) disable iff (rst) s_ser ##0 $fell(serial_bit_clock_out) |->
    hi_q == sample_period_reg) else $error("bit clock high phase wrong");
  a_ser_edges: assert property (@(posedge sclk) disable iff (rst) s_ser ##0
    ($changed(serial_data_or_mute_out) || $changed(word_select_left_out)) |-> $fell(serial_bit_clock_out))
    else $error("serial line moved off the falling bit clock");
  a_ana_mute: assert property (@(posedge sclk) disable iff (rst) s_ana ##0 serial_data_or_mute_out |->
    !anyp) else $error("pin driven during mute");
  a_ana_side: assert property (@(posedge sclk) disable iff (rst) s_ana ##0 anyp |->
    word_select_left_out == lpin) else $error("left flag disagrees with pins");
  a_rd_zero: assert property (@(posedge clk) disable iff (rst) !(reg_rd && reg_addr == CTRL_OFF) |=>
    reg_rdata == 8'h00) else $error("read data not zero");
  a_req_hold: assert property (@(posedge clk) disable iff (rst) dma_req && !dma_wr |=> dma_req)
    else $error("request dropped early");
  a_req_four: assert property (@(posedge clk) disable iff (rst) s_fill |=> !dma_req)
    else $error("request held after four words");
endmodule

bind sso_sound_out sso_checker u_sso_checker (.clk(clk), .rst(rst), .sclk(sclk), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sound_ctrl(sound_ctrl), .sample_period_reg(sample_period_reg),
  .dma_req(dma_req), .dma_wr(dma_wr), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_data_or_mute_out(serial_data_or_mute_out), .word_select_left_out(word_select_left_out),
  .left_plus_out(left_plus_out), .left_minus_out(left_minus_out), .right_plus_out(right_plus_out),
  .right_minus_out(right_minus_out));

// ### sim/sso_dac_model.sv
// Receiver model of the serial audio converter on the far side.
`timescale 1ns/100ps
module sso_dac_model (
  input  logic        sclk,     // Link clock.
  input  logic        rst,      // Reset, restarts frame counting.
  input  logic        bclk,     // Serial bit clock.
  input  logic        sdata,    // Serial data.
  input  logic        ws,       // Word select.
  output logic [31:0] frame,    // Last frame, first bit in bit 31.
  output logic [31:0] ws_bits,  // Word select seen with each bit.
  output logic        fvld      // One link cycle per frame.
);
  logic [31:0] sh_q;
  logic [31:0] wsh_q;
  logic [4:0]  cnt_q;
  logic        bclk_q;
  // thirty-two bits per frame; bits are taken on the rising bit clock, mid-bit.
  always @(posedge sclk) begin
    fvld <= 1'b0;
    bclk_q <= bclk;
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (bclk && !bclk_q) begin
      sh_q <= {sh_q[30:0], sdata};
      wsh_q <= {wsh_q[30:0], ws};
      cnt_q <= cnt_q + 5'h01;
      if (cnt_q == 5'h1f) begin
        frame <= {sh_q[30:0], sdata};
        ws_bits <= {wsh_q[30:0], ws};
        fvld <= 1'b1;
      end
    end
  end
endmodule

// ### sim/sso_sound_out_bench.sv
// Self-checking bench for the sound output block and its serial receiver.
`timescale 1ns/100ps
module sso_sound_out_bench
  import sso_pkg::*;
;
  logic        clk = 1'b0, sclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic        dma_wr = 1'b0, fmt = 1'b0, sdo_q = 1'b0, rd_d = 1'b0;
  logic [8:0]  reg_addr = 9'h000;
  logic [7:0]  reg_wdata = 8'h00, sample_period_reg = 8'h02, reg_rdata, b, v;
  logic [2:0]  sound_ctrl = 3'h0, sound_channel_out;
  logic [1:0]  channel_mode = 2'h3;
  logic [23:0] stereo_image_value = 24'h000000, img;
  logic [31:0] dma_wdata = 32'h00000000, frm, wsp, fexp;
  logic [6:0]  mag;
  logic        dma_req, bclk, sdo, ws, lp, lm, rp, rm, fvld;
  int          num_errors = 0, n_checks = 0, nf = 0, k = 0, slen = 0, lcnt = 0, on = 0;
  logic [7:0]  bq[$], rq[$];
  sso_sound_out u_sso_sound_out (.clk(clk), .rst(rst), .sclk(sclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sound_ctrl(sound_ctrl),
    .channel_mode(channel_mode), .sample_period_reg(sample_period_reg), .stereo_image_value(stereo_image_value),
    .dma_req(dma_req), .dma_wr(dma_wr), .dma_wdata(dma_wdata), .serial_bit_clock_out(bclk),
    .serial_data_or_mute_out(sdo), .word_select_left_out(ws), .left_plus_out(lp), .left_minus_out(lm),
    .right_plus_out(rp), .right_minus_out(rm), .dac_magnitude_out(mag), .sound_channel_out(sound_channel_out));
  sso_dac_model u_sso_dac_model (.sclk(sclk), .rst(rst), .bclk(bclk), .sdata(sdo), .ws(ws), .frame(frm),
    .ws_bits(wsp), .fvld(fvld));
  // System clock, and a link clock of unrelated phase.
  always #50 clk = ~clk;
  initial begin
    #37;
    forever #80 sclk = ~sclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d errors=%0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Strobes stay up between calls so accesses run back to back; reads note their expected data.
  task automatic reg_acc(input logic wr, input logic [8:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wr = wr;
    reg_rd = !wr;
    reg_wdata = d;
    if (!wr) rq.push_back(d);
    cyc(1);
  endtask
  // Reset starts idle; the latch still holds zero when the first slot goes out.
  task automatic do_reset;
    sound_ctrl = 3'h0;
    rst = 1'b1;
    cyc(8);
    bq.delete();
    bq.push_back(8'h00);
    rst = 1'b0;
  endtask
  task automatic await(input int n, input int lim);
    nf = 0;
    for (int t = 0; t < lim && nf < n; t++) cyc(1);
    if (nf < n) begin
      num_errors++;
      close_out();
    end
  endtask
  // Read data is due one cycle after the strobe.
  always @(posedge clk) rd_d <= reg_rd;
  always @(negedge clk) if (rd_d) chk(32'(reg_rdata), 32'(rq.pop_front()));
  // Answers every request with four words, noting their bytes; idle writes must be ignored.
  initial begin
    cyc(1);
    forever begin
      if (!rst && dma_req === 1'b1) begin
        for (int w = 0; w < 4; w++) begin
          dma_wdata = $urandom;
          dma_wr = 1'b1;
          for (int i = 0; i < 4; i++) bq.push_back(dma_wdata[8*i +: 8]);
          cyc(1);
        end
        if (!rst) chk(32'(dma_req), 32'h0);
      end else begin
        dma_wdata = ~dma_wdata;
        dma_wr = !rst && ($urandom % 8 == 0);
        cyc(1);
      end
    end
  end
  // Each received frame carries the next four noted bytes and the select pattern of its format.
  always @(posedge sclk) begin
    if (fvld === 1'b1 && sound_ctrl[2] && !rst) begin
      for (int i = 0; i < 4; i++) fexp = {fexp[23:0], bq.pop_front()};
      nf++;
      chk(frm, fexp);
      chk(wsp, fmt ? 32'hffff0000 : 32'h0001fffe);
    end
  end
  // Analog slots are timed from one mute rise to the next.
  always @(posedge sclk) begin
    if (rst || sound_ctrl[2:1] != 2'b01) begin
      on = 0;
      k = 0;
    end else if (sdo && !sdo_q) begin
      if (on) begin
        chk(slen, 32'(sample_period_reg) * CYC_PER_US);
        chk(lcnt, 3 * (7 - stereo_image_value[3*k +: 3]));
        k = (k + 1) % SLOTS;
        nf++;
      end
      on = 1;
      slen = 1;
      lcnt = 0;
    end else begin
      slen++;
      lcnt += int'(lp | lm);
      if (!sdo && sdo_q && on) begin
        b = bq.pop_front();
        chk(32'({mag, lp | rp, lm | rm}), 32'({b, ~b[0]}));
        chk(32'(sound_channel_out), k & ((1 << channel_mode) - 1));
      end
    end
    sdo_q = sdo;
  end
  initial begin
    v = 8'($urandom(32'h46418f8c));
    do_reset();
    reg_acc(1'b0, CTRL_OFF, CTRL_RST);
    for (int i = 0; i < 3; i++) begin
      v = 8'($urandom);
      reg_acc(1'b1, CTRL_OFF, v);
      reg_acc(1'b1, 9'h070, ~v);
      reg_acc(1'b0, 9'h070, 8'h00);
      reg_acc(1'b0, CTRL_OFF, v);
    end
    reg_rd = 1'b0;
    // Stay idle long enough for the idle-pin assertion to see a settled window.
    cyc(24);
    for (int f = 0; f < 2; f++) begin
      do_reset();
      fmt = f[0];
      reg_acc(1'b1, CTRL_OFF, {7'h00, fmt});
      reg_wr = 1'b0;
      // serial enable, clock select, period two
      sample_period_reg = 8'h02;
      sound_ctrl = 3'b101;
      await(6, 2000);
    end
    for (int m = 3; m >= 0; m--) begin
      do_reset();
      channel_mode = 2'(m);
      for (int s = 0; s < 8; s++) img[3*s +: 3] = 3'(1 + $urandom % 7);
      if (m == 2) img[23:12] = img[11:0];
      if (m == 0) img = {8{img[2:0]}};
      stereo_image_value = img;
      sample_period_reg = 8'(MIN_PER_US) + 8'h01;
      sound_ctrl = 3'b010;
      await(10, 1000);
    end
    close_out();
  end
endmodule
